// ==== hdl/pin_sync.sv ====
// Two-stage synchroniser for a group of asynchronous level inputs.
// Assumes the clock enable freezes the stages like all other state.
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 4
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_ce,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);

   logic [WIDTH-1:0] meta_q;

   // First stage is read only by the second stage.
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         meta_q <= '0;
         o_sync <= '0;
      end else if (i_ce) begin
         meta_q <= i_async;
         o_sync <= meta_q;
      end
   end

endmodule

// ==== hdl/watchdog_pkg.sv ====
// Package of shared constants for the watchdog timer and reset-cause block.
// Assumes a byte-wide register port and a single system clock.
package watchdog_pkg;

   // Register byte offsets on the plain register port.
   localparam logic [7:0] REG_CONTROL = 8'h60;
   localparam logic [7:0] REG_CAUSE = 8'h54;

   // Field positions inside the watchdog control register.
   localparam int CTL_IRQ_FLAG = 7;
   localparam int CTL_IRQ_EN = 6;
   localparam int CTL_PSEL3 = 5;
   localparam int CTL_CHG_EN = 4;
   localparam int CTL_RST_EN = 3;

   // Field positions inside the reset-cause register.
   localparam int CAUSE_DOG = 3;
   localparam int CAUSE_BROWN = 2;
   localparam int CAUSE_PIN = 1;
   localparam int CAUSE_PWR = 0;

   // Reset values and fixed fills.
   localparam logic [3:0] CAUSE_AT_POWERON = 4'h1;
   localparam logic [3:0] CAUSE_UNUSED = 4'h0;
   localparam logic [3:0] PSEL_RESET = 4'h0;
   localparam logic [3:0] PSEL_LONGEST = 4'h9;
   localparam logic [7:0] RDATA_IDLE = 8'h00;

   // Change-enable window length in system clock cycles.
   localparam logic [2:0] CHG_WINDOW_CYC = 3'h4;
   localparam logic [2:0] CHG_LAST_CYC = 3'h1;

   // Default time-out base in oscillator cycles.
   localparam int BASE_OSC_CYCLES = 2048;

   // Operating modes of the watchdog.
   typedef enum logic [1:0] {
      MODE_STOP,
      MODE_IRQ,
      MODE_RST,
      MODE_IRQ_RST
   } dog_mode_t;

endpackage

// ==== hdl/watchdog_unit.sv ====
// Watchdog timer with timed change protection and reset-cause flags.
// Assumes the oscillator, pin reset, brown-out and fuse arrive asynchronously.
`timescale 1ns/1ps
module watchdog_unit #(
   parameter int BASE_CYCLES = watchdog_pkg::BASE_OSC_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_ce,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   input wire logic i_dog_osc,
   input wire logic i_dog_always_on_fuse,
   input wire logic i_pin_reset,
   input wire logic i_brownout_reset,
   input wire logic i_dog_restart,
   input wire logic i_vector_ack,
   input wire logic i_global_irq_enable,
   output logic o_dog_irq,
   output logic o_dog_sys_reset
);

   localparam int CNT_W = $clog2(BASE_CYCLES) + 11;

   // Refuse a base that the shift-based limit cannot serve.
   if (BASE_CYCLES < 2 || (BASE_CYCLES & (BASE_CYCLES - 1)) != 0) begin : g_bad_base
      $error("BASE_CYCLES must be a power of two of at least two.");
   end

   logic [3:0] sync_w;
   logic osc_s;
   logic fuse_s;
   logic pin_s;
   logic brown_s;
   logic osc_last_q;
   logic tick;
   logic dog_irq_flag_q;
   logic dog_irq_enable_q;
   logic dog_reset_enable_q;
   logic dog_change_enable_q;
   logic [2:0] chg_cnt_q;
   logic [3:0] period_sel_q;
   logic [3:0] cause_q;
   logic [CNT_W-1:0] cnt_q;
   logic sys_rst_q;
   logic wr_ctl;
   logic wr_cause;
   logic soft_rst;
   logic ack;
   logic ie_eff;
   logic wde_eff;
   logic [3:0] psel_eff;
   logic [CNT_W-1:0] limit;
   logic timeout;
   logic irq_evt;
   logic dog_rst_evt;
   logic open_req;
   watchdog_pkg::dog_mode_t mode;

   // Bring the oscillator, fuse and reset pins into the clock domain.
   pin_sync #(
      .WIDTH(4)
   ) u_sync (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_ce(i_ce),
      .i_async({i_dog_always_on_fuse, i_brownout_reset, i_pin_reset, i_dog_osc}),
      .o_sync(sync_w)
   );

   assign osc_s = sync_w[0];
   assign pin_s = sync_w[1];
   assign brown_s = sync_w[2];
   assign fuse_s = sync_w[3];

   // Remember the last oscillator level so each rising edge is one tick.
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         osc_last_q <= 1'b0;
      end else if (i_ce) begin
         osc_last_q <= osc_s;
      end
   end

   assign tick = i_ce && osc_s && !osc_last_q;

   // Qualified strobes; all state freezes while the clock enable is low.
   assign wr_ctl = i_ce && i_wr && (i_addr == watchdog_pkg::REG_CONTROL);
   assign wr_cause = i_ce && i_wr && (i_addr == watchdog_pkg::REG_CAUSE);
   assign ack = i_ce && i_vector_ack;
   assign soft_rst = pin_s || brown_s || sys_rst_q;
   assign open_req = wr_ctl && i_wdata[watchdog_pkg::CTL_CHG_EN]
                     && i_wdata[watchdog_pkg::CTL_RST_EN];

   // Effective enables after the fuse and the dog cause flag override.
   assign ie_eff = dog_irq_enable_q && !fuse_s;
   assign wde_eff = dog_reset_enable_q || cause_q[watchdog_pkg::CAUSE_DOG]
                    || fuse_s;

   // Decode the operating mode.
   always_comb begin
      if (fuse_s) begin
         mode = watchdog_pkg::MODE_RST;
      end else begin
         case ({wde_eff, ie_eff})
            2'b01: mode = watchdog_pkg::MODE_IRQ;
            2'b10: mode = watchdog_pkg::MODE_RST;
            2'b11: mode = watchdog_pkg::MODE_IRQ_RST;
            default: mode = watchdog_pkg::MODE_STOP;
         endcase
      end
   end

   // Reserved period codes behave as the longest period.
   assign psel_eff = (period_sel_q > watchdog_pkg::PSEL_LONGEST) ?
                     watchdog_pkg::PSEL_LONGEST : period_sel_q;
   assign limit = CNT_W'(BASE_CYCLES) << psel_eff;

   // Time-out and the action that it takes in each mode.
   assign timeout = tick && (mode != watchdog_pkg::MODE_STOP)
                    && (cnt_q == limit - CNT_W'(1));
   assign irq_evt = timeout && ((mode == watchdog_pkg::MODE_IRQ)
                    || ((mode == watchdog_pkg::MODE_IRQ_RST) && !dog_irq_flag_q));
   assign dog_rst_evt = timeout && ((mode == watchdog_pkg::MODE_RST)
                        || ((mode == watchdog_pkg::MODE_IRQ_RST) && dog_irq_flag_q));

   // Oscillator cycle counter.
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         cnt_q <= '0;
      end else if (i_ce) begin
         if (i_dog_restart || timeout || soft_rst
             || mode == watchdog_pkg::MODE_STOP) begin
            cnt_q <= '0;
         end else if (tick) begin
            cnt_q <= cnt_q + CNT_W'(1);
         end
      end
   end

   // One-cycle system reset pulse from the watchdog.
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         sys_rst_q <= 1'b0;
      end else if (i_ce) begin
         sys_rst_q <= dog_rst_evt;
      end
   end

   assign o_dog_sys_reset = sys_rst_q;

   // Interrupt flag: a time-out in the same cycle as a clear wins.
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         dog_irq_flag_q <= 1'b0;
      end else if (i_ce) begin
         if (irq_evt) begin
            dog_irq_flag_q <= 1'b1;
         end else if (soft_rst || ack
                      || (wr_ctl && i_wdata[watchdog_pkg::CTL_IRQ_FLAG])) begin
            dog_irq_flag_q <= 1'b0;
         end
      end
   end

   // Interrupt enable: vector execution clears it, so interrupt-and-reset mode drops to reset-only.
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         dog_irq_enable_q <= 1'b0;
      end else if (i_ce) begin
         if (soft_rst || ack) begin
            dog_irq_enable_q <= 1'b0;
         end else if (wr_ctl) begin
            dog_irq_enable_q <= i_wdata[watchdog_pkg::CTL_IRQ_EN];
         end
      end
   end

   assign o_dog_irq = dog_irq_flag_q && ie_eff && i_global_irq_enable;

   // Change-enable window: opened by writing it with reset-enable,
   // closed by the next control write or after four cycles.
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         dog_change_enable_q <= 1'b0;
         chg_cnt_q <= '0;
      end else if (i_ce) begin
         if (soft_rst) begin
            dog_change_enable_q <= 1'b0;
            chg_cnt_q <= '0;
         end else if (dog_change_enable_q) begin
            chg_cnt_q <= chg_cnt_q - 3'h1;
            if (wr_ctl || chg_cnt_q == watchdog_pkg::CHG_LAST_CYC) begin
               dog_change_enable_q <= 1'b0;
            end
         end else if (open_req) begin
            dog_change_enable_q <= 1'b1;
            chg_cnt_q <= watchdog_pkg::CHG_WINDOW_CYC;
         end
      end
   end

   // Reset-enable: clearing needs the window and a clear dog cause flag.
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         dog_reset_enable_q <= 1'b0;
      end else if (i_ce) begin
         if (dog_rst_evt || cause_q[watchdog_pkg::CAUSE_DOG]) begin
            dog_reset_enable_q <= 1'b1;
         end else if (wr_ctl && dog_change_enable_q) begin
            dog_reset_enable_q <= i_wdata[watchdog_pkg::CTL_RST_EN];
         end else if (wr_ctl && i_wdata[watchdog_pkg::CTL_RST_EN]) begin
            dog_reset_enable_q <= 1'b1;
         end
      end
   end

   // Period select: written only inside the window; soft_rst reloads the reset code.
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         period_sel_q <= watchdog_pkg::PSEL_RESET;
      end else if (i_ce) begin
         if (soft_rst) begin
            period_sel_q <= watchdog_pkg::PSEL_RESET;
         end else if (wr_ctl && dog_change_enable_q) begin
            period_sel_q <= {i_wdata[watchdog_pkg::CTL_PSEL3], i_wdata[2:0]};
         end
      end
   end

   // Reset-cause flags: power-on sets only the power flag, any set
   // wins over a software write of zero.
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         cause_q <= watchdog_pkg::CAUSE_AT_POWERON;
      end else if (i_ce) begin
         cause_q <= (wr_cause ? (cause_q & i_wdata[3:0]) : cause_q)
                    | {dog_rst_evt, brown_s, pin_s, 1'b0};
      end
   end

   // Read data stand for exactly the cycle after the read strobe.
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_rdata <= watchdog_pkg::RDATA_IDLE;
      end else if (i_ce) begin
         if (i_rd && i_addr == watchdog_pkg::REG_CONTROL) begin
            o_rdata <= {dog_irq_flag_q, ie_eff, period_sel_q[3], dog_change_enable_q,
                        wde_eff, period_sel_q[2:0]};
         end else if (i_rd && i_addr == watchdog_pkg::REG_CAUSE) begin
            o_rdata <= {watchdog_pkg::CAUSE_UNUSED, cause_q};
         end else begin
            o_rdata <= watchdog_pkg::RDATA_IDLE;
         end
      end
   end

   // Checks on the block's own behaviour.
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rstn);

   sequence s_open;
      i_ce && open_req && !dog_change_enable_q && !soft_rst;
   endsequence

   sequence s_window;
      (dog_change_enable_q && i_ce && !wr_ctl && !soft_rst) [*4];
   endsequence

   property p_window_len;
      s_open ##1 s_window |=> !dog_change_enable_q;
   endproperty
   a_window_len: assert property (p_window_len) else $error("window not closed after four");

   property p_window_open;
      s_open |=> dog_change_enable_q ##0 (chg_cnt_q == watchdog_pkg::CHG_WINDOW_CYC);
   endproperty
   a_window_open: assert property (p_window_open) else $error("window did not open");

   property p_psel_guard;
      i_ce && !dog_change_enable_q && !soft_rst |=> $stable(period_sel_q);
   endproperty
   a_psel_guard: assert property (p_psel_guard) else $error("period changed without window");

   property p_dog_cause;
      dog_rst_evt |=> o_dog_sys_reset && cause_q[3] && wde_eff;
   endproperty
   a_dog_cause: assert property (p_dog_cause) else $error("dog reset did not mark cause");

   property p_wde_forced;
      i_ce && cause_q[watchdog_pkg::CAUSE_DOG] |=> dog_reset_enable_q && wde_eff;
   endproperty
   a_wde_forced: assert property (p_wde_forced) else $error("reset enable not forced");

   property p_irq_gate;
      o_dog_irq |-> i_global_irq_enable && dog_irq_enable_q && !fuse_s;
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq without both enables");

   property p_irq_set;
      irq_evt |=> dog_irq_flag_q && (cnt_q == '0);
   endproperty
   a_irq_set: assert property (p_irq_set) else $error("interrupt time-out not taken");

   property p_ack_clear;
      ack && !irq_evt |=> !dog_irq_flag_q && !dog_irq_enable_q;
   endproperty
   a_ack_clear: assert property (p_ack_clear) else $error("vector did not clear flag");

   property p_cause_top;
      i_ce && i_rd && i_addr == watchdog_pkg::REG_CAUSE |=> o_rdata[7:4] == 4'h0;
   endproperty
   a_cause_top: assert property (p_cause_top) else $error("unused cause bits not zero");

   property p_fuse_mode;
      fuse_s |-> mode == watchdog_pkg::MODE_RST && !ie_eff;
   endproperty
   a_fuse_mode: assert property (p_fuse_mode) else $error("fuse did not force reset mode");

   property p_restart;
      i_ce && i_dog_restart |=> cnt_q == '0;
   endproperty
   a_restart: assert property (p_restart) else $error("restart did not clear counter");

endmodule

// ==== verification/tb_watchdog_timer_with_reset_flags.sv ====
// Self-checking testbench for the watchdog timer with reset-cause flags.
// Assumes watchdog_unit and watchdog_pkg are compiled first; runs one 10 MHz clock.
`timescale 1ns/1ps
`define CHECK_EQ(nm, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
   $display("FAIL %s expected %h seen %h", nm, e, g); end end
module tb_watchdog_timer_with_reset_flags;
   localparam int BASE = 4;
   logic i_clk, i_rstn, i_ce, i_wr, i_rd, i_dog_osc, i_dog_always_on_fuse;
   logic i_pin_reset, i_brownout_reset, i_dog_restart, i_vector_ack, i_global_irq_enable;
   logic [7:0] i_addr, i_wdata, o_rdata, seed, v;
   logic o_dog_irq, o_dog_sys_reset;
   int num_errors = 0;
   int tests_run = 0;
   int rst_cnt = 0;

   watchdog_unit #(.BASE_CYCLES(BASE)) dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(i_ce),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_dog_osc(i_dog_osc), .i_dog_always_on_fuse(i_dog_always_on_fuse),
      .i_pin_reset(i_pin_reset), .i_brownout_reset(i_brownout_reset),
      .i_dog_restart(i_dog_restart), .i_vector_ack(i_vector_ack),
      .i_global_irq_enable(i_global_irq_enable), .o_dog_irq(o_dog_irq),
      .o_dog_sys_reset(o_dog_sys_reset));

   // Clock of 100 ns period.
   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end

   // Counts every cycle in which the watchdog reset pulse is high.
   always @(posedge i_clk) begin
      if (o_dog_sys_reset === 1'b1) begin
         rst_cnt <= rst_cnt + 1;
      end
   end

   // Next value of the eight-bit random sequence.
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction

   // Oscillator ticks up to a time-out for a period code.
   function automatic int ticks_for(input logic [3:0] code);
      return BASE << code;
   endfunction

   // One register write cycle.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask

   // One register read cycle; the data is taken in the cycle after the strobe.
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      @(negedge i_clk);
      d = o_rdata;
   endtask

   // Reads a register and compares the whole byte.
   task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string nm);
      logic [7:0] d;
      rd(a, d);
      `CHECK_EQ(nm, e, d)
   endtask

   // Gives n rising edges of the slow oscillator, each long enough to pass the synchroniser.
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge i_clk);
         i_dog_osc <= 1'b1;
         repeat (4) @(posedge i_clk);
         i_dog_osc <= 1'b0;
         repeat (4) @(posedge i_clk);
      end
   endtask

   // Timed sequence: opening write, then the new setting inside the window.
   task automatic timed(input logic [7:0] d);
      @(posedge i_clk);
      i_dog_restart <= 1'b1;
      @(posedge i_clk);
      i_dog_restart <= 1'b0;
      wr(8'h60, 8'h18);
      wr(8'h60, d);
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Cuts a hang short well beyond the expected run length.
   initial begin
      repeat (20000) @(posedge i_clk);
      num_errors++;
      give_verdict();
   end

   // Main sequence of tests.
   initial begin
      i_rstn = 1'b0;
      i_ce = 1'b1;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_addr = 8'h00;
      i_wdata = 8'h00;
      i_dog_osc = 1'b0;
      i_dog_always_on_fuse = 1'b0;
      i_pin_reset = 1'b0;
      i_brownout_reset = 1'b0;
      i_dog_restart = 1'b0;
      i_vector_ack = 1'b0;
      i_global_irq_enable = 1'b0;
      seed = 8'h4c;
      repeat (2) @(posedge i_clk);
      i_rstn <= 1'b1;
      repeat (3) @(posedge i_clk);
      rdc(8'h54, 8'h01, "cause_poweron");
      rdc(8'h60, 8'h00, "control_reset");
      repeat (6) begin
         seed = lfsr(seed);
         v = (seed == 8'h54 || seed == 8'h60) ? ~seed : seed;
         wr(v, lfsr(seed));
         rdc(v, 8'h00, "unmapped");
      end
      wr(8'h54, 8'hf0);
      rdc(8'h54, 8'h00, "cause_cleared");
      $display("test reset values done");
      @(posedge i_clk);
      i_pin_reset <= 1'b1;
      repeat (4) @(posedge i_clk);
      i_pin_reset <= 1'b0;
      repeat (4) @(posedge i_clk);
      rdc(8'h54, 8'h02, "cause_pin");
      @(posedge i_clk);
      i_brownout_reset <= 1'b1;
      repeat (4) @(posedge i_clk);
      i_brownout_reset <= 1'b0;
      repeat (4) @(posedge i_clk);
      rdc(8'h54, 8'h06, "cause_brown");
      wr(8'h54, 8'h04);
      rdc(8'h54, 8'h04, "cause_partial_clear");
      wr(8'h54, 8'h00);
      rdc(8'h54, 8'h00, "cause_brown_clear");
      $display("test reset causes done");
      wr(8'h60, 8'h05);
      rdc(8'h60, 8'h00, "period_locked");
      wr(8'h60, 8'h08);
      rdc(8'h60, 8'h08, "reset_enable_set");
      wr(8'h60, 8'h00);
      rdc(8'h60, 8'h08, "reset_enable_locked");
      wr(8'h60, 8'h18);
      @(posedge i_clk);
      rdc(8'h60, 8'h18, "window_open");
      rdc(8'h60, 8'h08, "window_closed");
      timed(8'h41);
      rdc(8'h60, 8'h41, "timed_change");
      $display("test timed sequence done");
      @(posedge i_clk);
      i_global_irq_enable <= 1'b1;
      tick(ticks_for(4'h1) - 1);
      rdc(8'h60, 8'h41, "no_early_timeout");
      tick(1);
      rdc(8'h60, 8'hc1, "irq_flag_set");
      `CHECK_EQ("irq_request", 1'b1, o_dog_irq)
      @(posedge i_clk);
      i_global_irq_enable <= 1'b0;
      @(negedge i_clk);
      `CHECK_EQ("irq_masked", 1'b0, o_dog_irq)
      @(posedge i_clk);
      i_global_irq_enable <= 1'b1;
      wr(8'h60, 8'hc1);
      rdc(8'h60, 8'h41, "flag_write_one");
      tick(ticks_for(4'h1));
      rdc(8'h60, 8'hc1, "irq_again");
      @(posedge i_clk);
      i_vector_ack <= 1'b1;
      @(posedge i_clk);
      i_vector_ack <= 1'b0;
      rd(8'h60, v);
      `CHECK_EQ("flag_vector", 1'b0, v[7])
      wr(8'h60, 8'h41);
      tick(2 * BASE - 2);
      @(posedge i_clk);
      i_dog_restart <= 1'b1;
      @(posedge i_clk);
      i_dog_restart <= 1'b0;
      tick(2 * BASE - 2);
      rdc(8'h60, 8'h41, "restart_holds");
      tick(2);
      rdc(8'h60, 8'hc1, "restart_count");
      $display("test interrupt mode done");
      timed(8'hc8);
      rdc(8'h60, 8'h48, "both_mode");
      tick(BASE);
      rdc(8'h60, 8'hc8, "first_timeout");
      `CHECK_EQ("no_reset_yet", 0, rst_cnt)
      @(posedge i_clk);
      i_vector_ack <= 1'b1;
      @(posedge i_clk);
      i_vector_ack <= 1'b0;
      rdc(8'h60, 8'h08, "vector_clears");
      wr(8'h60, 8'h48);
      tick(BASE);
      rdc(8'h60, 8'hc8, "flag_pending");
      tick(BASE);
      `CHECK_EQ("unserved_reset", 1, rst_cnt)
      rdc(8'h54, 8'h08, "cause_dog");
      rdc(8'h60, 8'h08, "after_dog_reset");
      $display("test interrupt then reset done");
      timed(8'h00);
      rdc(8'h60, 8'h08, "forced_enable");
      tick(BASE);
      `CHECK_EQ("reset_mode", 2, rst_cnt)
      wr(8'h54, 8'h00);
      rdc(8'h54, 8'h00, "cause_dog_clear");
      timed(8'h00);
      rdc(8'h60, 8'h00, "enable_released");
      tick(2 * BASE);
      `CHECK_EQ("stopped", 2, rst_cnt)
      $display("test reset mode done");
      i_dog_always_on_fuse <= 1'b1;
      repeat (4) @(posedge i_clk);
      wr(8'h60, 8'h40);
      rdc(8'h60, 8'h08, "fuse_lock");
      tick(BASE);
      `CHECK_EQ("fuse_reset", 3, rst_cnt)
      i_dog_always_on_fuse <= 1'b0;
      $display("test fuse done");
      // With the clock enable low, neither a cause write nor oscillator ticks may act.
      @(posedge i_clk);
      i_ce <= 1'b0;
      wr(8'h54, 8'h00);
      tick(2 * ticks_for(4'h0));
      @(posedge i_clk);
      i_ce <= 1'b1;
      rdc(8'h54, 8'h08, "ce_freeze_cause");
      `CHECK_EQ("ce_freeze_count", 3, rst_cnt)
      $display("test clock enable done");
      give_verdict();
   end
endmodule
